// File: pkg/pulse_timer_defs.vh
`ifndef PULSE_TIMER_DEFS_VH
`define PULSE_TIMER_DEFS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define REG_TIMER_SEL 6'h00
`define REG_DUR_RAW 6'h04
`define REG_DUR_ABS 6'h08
`define REG_DUR_BASE 6'h0c
`define REG_DLY_RAW 6'h10
`define REG_DLY_BASE 6'h14
`define REG_LINE_SEL 6'h18
`define REG_LINE_STATE 6'h1c
`define REG_LINE_ALL 6'h20
// ----------------------------------------
// field widths and reset values
// ----------------------------------------
`define RAW_W 12
`define BASE_W 16
`define ABS_W 28
`define DUR_RAW_RST 12'h001
`define DUR_RAW_MIN 12'h001
`define DLY_RAW_RST 12'h000
`define BASE_RST 16'h0001
// ----------------------------------------
// line status word layout
// ----------------------------------------
`define LINE_IN_LSB 0
`define LINE_OUT_LSB 16
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ 200
`define TICK_US 1
`define TICK_CYC (`CLK_MHZ * `TICK_US)
`define TICK_MAX 8'd199
`endif

// File: logic/pulse_timer_chan.v
`timescale 1ns/1ps
`default_nettype none
`include "pulse_timer_defs.vh"
module pulse_timer_chan (
   // clock and reset
   input wire clk_i,
   input wire rstn_i,
   // timing controls
   input wire tick_i,
   input wire start_i,
   input wire [`RAW_W-1:0] dly_raw_i,
   input wire [`RAW_W-1:0] dur_raw_i,
   input wire [`BASE_W-1:0] dly_base_i,
   input wire [`BASE_W-1:0] dur_base_i,
   // output line
   output reg line_o
);
   localparam ST_IDLE = 2'd0;
   localparam ST_DLY = 2'd1;
   localparam ST_HIGH = 2'd2;
   reg [1:0] state;
   reg [`BASE_W-1:0] base_cnt;
   reg [`RAW_W-1:0] raw_cnt;
   // ----------------------------------------
   // delay then high phase, counted in base units of 1 us ticks
   // ----------------------------------------
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state <= ST_IDLE;
         base_cnt <= {`BASE_W{1'b0}};
         raw_cnt <= {`RAW_W{1'b0}};
         line_o <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               // triggers during delay/high fall here only when idle [R18]
               if (start_i) begin // [R13]
                  base_cnt <= {`BASE_W{1'b0}};
                  raw_cnt <= {`RAW_W{1'b0}};
                  if (dly_raw_i == {`RAW_W{1'b0}}) begin
                     state <= ST_HIGH;
                     line_o <= 1'b1;
                  end else begin
                     state <= ST_DLY;
                  end
               end
            end
            ST_DLY: begin
               if (tick_i) begin // [R17]
                  if (base_cnt + 16'h0001 >= dly_base_i) begin
                     base_cnt <= {`BASE_W{1'b0}};
                     // delay = raw x delay base [R16]
                     if (raw_cnt + 12'h001 >= dly_raw_i) begin
                        raw_cnt <= {`RAW_W{1'b0}};
                        state <= ST_HIGH;
                        line_o <= 1'b1; // [R13]
                     end else begin
                        raw_cnt <= raw_cnt + 12'h001;
                     end
                  end else begin
                     base_cnt <= base_cnt + 16'h0001;
                  end
               end
            end
            ST_HIGH: begin
               if (tick_i) begin // [R17]
                  if (base_cnt + 16'h0001 >= dur_base_i) begin
                     base_cnt <= {`BASE_W{1'b0}};
                     // high time = raw x duration base [R1]
                     if (raw_cnt + 12'h001 >= dur_raw_i) begin
                        raw_cnt <= {`RAW_W{1'b0}};
                        state <= ST_IDLE;
                        line_o <= 1'b0; // [R13]
                     end else begin
                        raw_cnt <= raw_cnt + 12'h001;
                     end
                  end else begin
                     base_cnt <= base_cnt + 16'h0001;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
               line_o <= 1'b0;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// File: logic/output_timer_duration_status.v
// What this block does
// R1: High time of each timer equals raw duration count times shared duration base.
// R2: Duration time base resets to one microsecond.
// R3: Raw duration accepts 1 to 4095; software keeps within that range.
// R4: Duration base is software set in whole microseconds, one microsecond steps.
// R5: One duration time base serves all four timers.
// R6: Absolute duration write is divided by the base and stored as raw.
// R7: Software writes absolute durations that are exact multiples of the base.
// R8: Absolute duration read returns raw count times base in microseconds.
// R9: Raw duration write updates the absolute view at once.
// R10: Timer select picks which timer raw and absolute accesses reach.
// R11: Single line state reads 1 when selected line is high, else 0.
// R12: A 32-bit word shows every input and output line state.
// R13: On trigger a timer counts delay, drives high, then low after duration.
// R14: Exposure start is the only timer trigger.
// R15: Timer n drives output line n only.
// R16: Raw delay accepts 0 to 4095, times a separate delay base.
// R17: A prescaler makes a one microsecond tick that advances the counters.
// R18: Triggers during delay or high phase are ignored.
//
// Decided for this implementation: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pulse_timer_defs.vh"
module output_timer_duration_status (
   // clock and reset
   input wire clk_i,
   input wire rstn_i,
   // avalon-mm slave
   input wire [5:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [3:0] avs_byteenable_i,
   output reg [31:0] avs_readdata_o,
   output reg avs_waitrequest_o,
   // camera side
   input wire exposure_active_i,
   input wire [3:0] in_lines_i,
   // output lines
   output reg [3:0] out_lines_o
);
   // ----------------------------------------
   // configuration storage
   // ----------------------------------------
   reg [1:0] timer_sel;
   reg [`RAW_W-1:0] dur_raw [0:3];
   reg [`RAW_W-1:0] dly_raw [0:3];
   reg [`BASE_W-1:0] dur_base;
   reg [`BASE_W-1:0] dly_base;
   reg [4:0] line_sel;
   // ----------------------------------------
   // bus handshake and divider
   // ----------------------------------------
   reg busy;
   reg div_run;
   reg [`ABS_W-1:0] div_rem;
   reg [`RAW_W:0] div_q;
   reg [7:0] tick_cnt;
   reg tick;
   reg [2:0] exp_sync;
   reg exp_level;
   reg exp_start;
   reg [3:0] in_s1;
   reg [3:0] in_s2;
   reg [3:0] in_s3;
   reg [3:0] in_state;
   wire [3:0] line_q;
   wire [31:0] line_all;
   wire [`ABS_W-1:0] dur_abs;
   wire req;
   integer i;
   genvar g;

   assign req = avs_read_i | avs_write_i;
   // raw times base, recomputed from stored raw so it tracks every write [R8] [R9]
   assign dur_abs = dur_raw[timer_sel] * dur_base;
   // all lines word: inputs low half, outputs upper half [R12]
   assign line_all = {12'h000, out_lines_o, 12'h000, in_state};

   // ----------------------------------------
   // 1 us tick prescaler
   // ----------------------------------------
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tick_cnt <= 8'h00;
         tick <= 1'b0;
      end else if (tick_cnt == `TICK_MAX) begin // [R17]
         tick_cnt <= 8'h00;
         tick <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 8'h01;
         tick <= 1'b0;
      end
   end

   // ----------------------------------------
   // pin synchronisers, three stages with agreement filter
   // ----------------------------------------
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         exp_sync <= 3'h0;
         exp_level <= 1'b0;
         exp_start <= 1'b0;
         in_s1 <= 4'h0;
         in_s2 <= 4'h0;
         in_s3 <= 4'h0;
         in_state <= 4'h0;
      end else begin
         exp_sync <= {exp_sync[1:0], exposure_active_i};
         exp_start <= 1'b0;
         if (exp_sync[1] == exp_sync[2]) begin
            exp_level <= exp_sync[2];
            // rising edge of exposure active is the only trigger [R14]
            exp_start <= exp_sync[2] & ~exp_level;
         end
         in_s1 <= in_lines_i;
         in_s2 <= in_s1;
         in_s3 <= in_s2;
         for (i = 0; i < 4; i = i + 1) begin
            if (in_s2[i] == in_s3[i]) begin
               in_state[i] <= in_s3[i];
            end
         end
      end
   end

   // ----------------------------------------
   // four timers, timer n owns line n
   // ----------------------------------------
   generate
      for (g = 0; g < 4; g = g + 1) begin : gen_chan
         pulse_timer_chan u_chan (
            .clk_i(clk_i),
            .rstn_i(rstn_i),
            .tick_i(tick),
            .start_i(exp_start),
            .dly_raw_i(dly_raw[g]),
            .dur_raw_i(dur_raw[g]),
            .dly_base_i(dly_base),
            .dur_base_i(dur_base), // one shared base [R5]
            .line_o(line_q[g]) // [R15]
         );
      end
   endgenerate

   // register the lines once more so the top outputs come from flops
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         out_lines_o <= 4'h0;
      end else begin
         out_lines_o <= line_q; // [R15]
      end
   end

   // ----------------------------------------
   // register file: one cycle wait, absolute writes hold off until divided
   // ----------------------------------------
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         timer_sel <= 2'd0;
         dur_base <= `BASE_RST; // [R2]
         dly_base <= `BASE_RST;
         line_sel <= 5'd0;
         busy <= 1'b0;
         div_run <= 1'b0;
         div_rem <= {`ABS_W{1'b0}};
         div_q <= {(`RAW_W+1){1'b0}};
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o <= 32'h00000000;
         for (i = 0; i < 4; i = i + 1) begin
            dur_raw[i] <= `DUR_RAW_RST;
            dly_raw[i] <= `DLY_RAW_RST;
         end
      end else begin
         avs_waitrequest_o <= 1'b1;
         if (div_run) begin
            // repeated subtraction; at most 4096 steps, exact for legal multiples [R7]
            if (div_rem >= {12'h000, dur_base} && div_q < 13'h1000) begin
               div_rem <= div_rem - {12'h000, dur_base};
               div_q <= div_q + 13'h0001;
            end else begin
               div_run <= 1'b0;
               // dead cycle after the answer, else the still raised request is taken twice
               busy <= 1'b1;
               avs_waitrequest_o <= 1'b0;
               // out of range quotients are clamped to the legal raw span [R3]
               if (div_q == 13'h0000) begin
                  dur_raw[timer_sel] <= `DUR_RAW_MIN; // [R6]
               end else if (div_q > 13'h0fff) begin
                  dur_raw[timer_sel] <= 12'hfff;
               end else begin
                  dur_raw[timer_sel] <= div_q[`RAW_W-1:0]; // [R6] [R10]
               end
            end
         end else if (busy) begin
            busy <= 1'b0;
         end else if (req) begin
            busy <= 1'b1;
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o <= 32'h00000000;
            if (avs_write_i && avs_byteenable_i == 4'hf) begin
               case (avs_address_i)
                  `REG_TIMER_SEL: timer_sel <= avs_writedata_i[1:0]; // [R10]
                  `REG_DUR_RAW: begin
                     // zero is not a legal duration; the write is ignored and the old raw value kept [R3]
                     if (avs_writedata_i[11:0] != 12'h000) begin
                        dur_raw[timer_sel] <= avs_writedata_i[11:0]; // [R10] [R9]
                     end
                  end
                  `REG_DUR_ABS: begin
                     busy <= 1'b0;
                     avs_waitrequest_o <= 1'b1;
                     div_run <= 1'b1;
                     div_rem <= avs_writedata_i[`ABS_W-1:0];
                     div_q <= 13'h0000;
                  end
                  `REG_DUR_BASE: begin
                     // whole microseconds, minimum one [R4]
                     if (avs_writedata_i[15:0] != 16'h0000) begin
                        dur_base <= avs_writedata_i[15:0];
                     end
                  end
                  `REG_DLY_RAW: dly_raw[timer_sel] <= avs_writedata_i[11:0]; // [R16]
                  `REG_DLY_BASE: begin
                     if (avs_writedata_i[15:0] != 16'h0000) begin
                        dly_base <= avs_writedata_i[15:0];
                     end
                  end
                  `REG_LINE_SEL: line_sel <= avs_writedata_i[4:0];
                  default: begin
                  end
               endcase
            end else if (avs_read_i) begin
               case (avs_address_i)
                  `REG_TIMER_SEL: avs_readdata_o <= {30'h0, timer_sel};
                  `REG_DUR_RAW: avs_readdata_o <= {20'h0, dur_raw[timer_sel]};
                  `REG_DUR_ABS: avs_readdata_o <= {4'h0, dur_abs}; // [R8]
                  `REG_DUR_BASE: avs_readdata_o <= {16'h0, dur_base};
                  `REG_DLY_RAW: avs_readdata_o <= {20'h0, dly_raw[timer_sel]};
                  `REG_DLY_BASE: avs_readdata_o <= {16'h0, dly_base};
                  `REG_LINE_SEL: avs_readdata_o <= {27'h0, line_sel};
                  `REG_LINE_STATE: avs_readdata_o <= {31'h0, line_all[line_sel]}; // [R11]
                  `REG_LINE_ALL: avs_readdata_o <= line_all; // [R12]
                  default: avs_readdata_o <= 32'h00000000;
               endcase
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: dv/output_timer_duration_status_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pulse_line_checker (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // register bus
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   // timer side
   input wire logic exposure_active_i,
   input wire logic [3:0] out_lines_o
);
   // ----------------------------------------
   // helper and properties
   // ----------------------------------------
   logic seen;
   // remembers any trigger since reset; before it no line may move
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i)
         seen <= 1'b0;
      else if (exposure_active_i)
         seen <= 1'b1;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   a_answer_one_cycle: assert property (
      !avs_waitrequest_o |=> avs_waitrequest_o) else $error("answer longer than one cycle");
   a_answer_asked: assert property (
      !avs_waitrequest_o |-> $past(avs_read_i || avs_write_i)) else $error("answer unasked");
   a_read_prompt: assert property (
      $rose(avs_read_i) |-> ##[1:3] !avs_waitrequest_o) else $error("read not answered");
   a_write_prompt: assert property (
      $rose(avs_write_i) && avs_address_i != 6'h08 |-> ##[1:3] !avs_waitrequest_o)
      else $error("write not answered");
   a_state_bit: assert property (
      !avs_waitrequest_o && avs_read_i && avs_address_i == 6'h1c |-> avs_readdata_o[31:1] == 0)
      else $error("line state spare bits set");
   a_all_spare: assert property (
      !avs_waitrequest_o && avs_read_i && avs_address_i == 6'h20
      |-> avs_readdata_o[31:20] == 0 && avs_readdata_o[15:4] == 0) else $error("spare bits set");
   a_high_min: assert property (
      $rose(out_lines_o[0]) |-> out_lines_o[0] [*8]) else $error("pulse too short");
   a_no_trigger: assert property (
      !seen |-> out_lines_o == 4'h0) else $error("line high without trigger");
endmodule
bind output_timer_duration_status pulse_line_checker u_pulse_line_checker (
   .clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .exposure_active_i(exposure_active_i),
   .out_lines_o(out_lines_o));
`default_nettype wire

// File: dv/line_equipment.sv
`timescale 1ns/1ps
`default_nettype none
module line_equipment (
   // clock and clear
   input wire logic clk_i,
   input wire logic clr_i,
   // lines
   input wire logic [3:0] lines_i,
   output logic [3:0] in_lines_o,
   // measured pulses
   output logic [63:0] width_o,
   output logic [15:0] rises_o
);
   // ----------------------------------------
   // pulse meters
   // ----------------------------------------
   logic [63:0] run;
   assign in_lines_o = 4'ha; // fixed pattern so the readback is known
   // one meter per line: a stray drive shows up on the wrong meter
   always @(posedge clk_i) begin
      for (int i = 0; i < 4; i++) begin
         if (clr_i) begin
            run[i*16+:16] <= 16'h0;
            width_o[i*16+:16] <= 16'h0;
            rises_o[i*4+:4] <= 4'h0;
         end else if (lines_i[i]) begin
            run[i*16+:16] <= run[i*16+:16] + 16'h1;
         end else if (run[i*16+:16] != 16'h0) begin
            width_o[i*16+:16] <= run[i*16+:16];
            rises_o[i*4+:4] <= rises_o[i*4+:4] + 4'h1;
            run[i*16+:16] <= 16'h0;
         end
      end
   end
endmodule
`default_nettype wire

// File: dv/tb_output_timer_duration_status.sv
`timescale 1ns/1ps
`default_nettype none
`include "pulse_timer_defs.vh"
module tb_output_timer_duration_status;
   // ----------------------------------------
   // wiring
   // ----------------------------------------
   logic clk_i = 0;
   logic rstn_i = 0;
   logic [5:0] avs_address_i = 6'h0;
   logic avs_read_i = 0;
   logic avs_write_i = 0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0] avs_byteenable_i = 4'hf;
   logic exposure_active_i = 0;
   logic clr = 0;
   wire [31:0] avs_readdata_o;
   wire avs_waitrequest_o;
   wire [3:0] in_lines_i;
   wire [3:0] out_lines_o;
   wire [63:0] width;
   wire [15:0] rises;
   logic [31:0] q;
   int fails = 0;
   int total_checks = 0;
   output_timer_duration_status u_output_timer_duration_status (.clk_i(clk_i),
      .rstn_i(rstn_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .exposure_active_i(exposure_active_i),
      .in_lines_i(in_lines_i), .out_lines_o(out_lines_o));
   line_equipment u_line_equipment (.clk_i(clk_i), .clr_i(clr), .lines_i(out_lines_o),
      .in_lines_o(in_lines_i), .width_o(width), .rises_o(rises));
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   // ----------------------------------------
   // bus and compare tasks
   // ----------------------------------------
   // request held until waitrequest is sampled low; no fixed latency assumed
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      @(posedge clk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_read_i <= !wr;
      avs_write_i <= wr;
      do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
      q = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [5:0] a);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_resets;
      rd(`REG_TIMER_SEL);
      chk(q, 32'h0);
      rd(`REG_DUR_RAW);
      chk(q, 32'h1);
      rd(`REG_DUR_ABS);
      chk(q, 32'h1);
      rd(`REG_DUR_BASE);
      chk(q, 32'h1);
      rd(`REG_DLY_RAW);
      chk(q, 32'h0);
      rd(6'h24);
      chk(q, 32'h0);
   endtask
   // absolute view against raw count, refusals, and per-timer selection
   task automatic t_abs;
      wr(`REG_DUR_BASE, 32'h5);
      wr(`REG_TIMER_SEL, 32'h2);
      wr(`REG_DUR_ABS, 32'd50); // exact multiple of the base
      rd(`REG_DUR_RAW);
      chk(q, 32'd10);
      rd(`REG_DUR_ABS);
      chk(q, 32'd50);
      wr(`REG_DUR_RAW, 32'h7);
      rd(`REG_DUR_ABS);
      chk(q, 32'd35);
      wr(`REG_DUR_RAW, 32'h0);
      avs_byteenable_i <= 4'h3;
      wr(`REG_DUR_RAW, 32'h9);
      avs_byteenable_i <= 4'hf;
      rd(`REG_DUR_RAW);
      chk(q, 32'h7);
      wr(`REG_DUR_BASE, 32'h0);
      rd(`REG_DUR_BASE);
      chk(q, 32'h5);
      wr(`REG_DUR_BASE, 32'h6);
      wr(`REG_TIMER_SEL, 32'h0);
      rd(`REG_DUR_RAW);
      chk(q, 32'h1);
      rd(`REG_DUR_ABS);
      chk(q, 32'h6);
   endtask
   // timer 0: delay 2, high 3 base units; second trigger lands while busy
   task automatic t_pulse(input int b);
      int e;
      e = 600 * b;
      wr(`REG_TIMER_SEL, 32'h0);
      wr(`REG_DUR_RAW, 32'h3);
      wr(`REG_DLY_RAW, 32'h2);
      wr(`REG_TIMER_SEL, 32'h1);
      wr(`REG_DUR_RAW, 32'h1);
      wr(`REG_LINE_SEL, 32'h10);
      wr(`REG_DUR_BASE, b);
      clr <= 1'b1;
      @(posedge clk_i);
      clr <= 1'b0;
      exposure_active_i <= 1'b1;
      repeat (30) @(posedge clk_i);
      exposure_active_i <= 1'b0;
      repeat (30) @(posedge clk_i);
      exposure_active_i <= 1'b1;
      while (out_lines_o[0] !== 1'b1) @(posedge clk_i);
      rd(`REG_LINE_STATE);
      chk(q, 32'h1);
      rd(`REG_LINE_ALL);
      chk(q & 32'h1000f, 32'h1000a);
      while (out_lines_o !== 4'h0) @(posedge clk_i);
      repeat (2) @(posedge clk_i);
      exposure_active_i <= 1'b0;
      rd(`REG_LINE_STATE);
      chk(q, 32'h0);
      chk(rises, 16'h1111);
      chk(32'(width[15:0] > e - 200 && width[15:0] <= e + 1), 32'h1);
      chk(32'(width[31:16] > e / 3 - 200 && width[31:16] <= e / 3 + 1), 32'h1);
   endtask
   // ----------------------------------------
   // sequence, watchdog and verdict
   // ----------------------------------------
   task automatic end_of_test;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk_i);
      rstn_i <= 1'b1;
      t_resets;
      t_abs;
      t_pulse(1);
      t_pulse(2);
      end_of_test;
   end
   // whole run needs some 21 us; a hang is cut off well after that
   initial begin
      #300000;
      fails++;
      end_of_test;
   end
endmodule
`default_nettype wire
